/* File: pdp_regs.vh */
`ifndef PDP_REGS_VH
`define PDP_REGS_VH

// Register indices; byte address is four times the index
`define PDP_TWO_IDX 10'h096
`define PDP_THREE_IDX 10'h098
`define PDP_CTRL_IDX 10'h09c
`define PDP_STAT_IDX 10'h09d

`define PDP_TWO_RESET 32'h00000000
`define PDP_THREE_RESET 32'h00000000
`define PDP_CTRL_RESET 32'h00000000

// Profile fields
`define PDP_PARITY_BIT 31
`define PDP_STEP0_MSB 30
`define PDP_STEP_W 3
`define PDP_RSVD_MSB 6

// Control fields
`define PDP_CTRL_EN_BIT 0
`define PDP_CTRL_DIV_LSB 8
`define PDP_CTRL_DIV_W 8

// Status fields
`define PDP_STAT_STEP_LSB 0
`define PDP_STAT_MODE_BIT 3
`define PDP_STAT_CODE_LSB 4
`define PDP_STAT_PWM_BIT 7
`define PDP_STAT_CNT_LSB 16

// Duty in hundredths of a percent
`define PDP_DUTY_W 14
`define PDP_DUTY_C0 14'h0000
`define PDP_DUTY_C1 14'h1388
`define PDP_DUTY_C2 14'h1d4c
`define PDP_DUTY_C3 14'h20b7
`define PDP_DUTY_C4 14'h222e
`define PDP_DUTY_C5 14'h249f
`define PDP_DUTY_C6 14'h2616
`define PDP_DUTY_C7 14'h26ac
`define PDP_DUTY_FULL 14'h2710

`endif

/* File: pdp_duty_lut.v */
`timescale 1ns/1ps
`include "pdp_regs.vh"

module pdp_duty_lut (
  input wire [2:0] code,                   // Step duty code
  output reg [`PDP_DUTY_W-1:0] duty        // Duty, hundredths of percent
);

  always @*
  begin
    case (code) // [R03]
      3'h0: duty = `PDP_DUTY_C0;
      3'h1: duty = `PDP_DUTY_C1;
      3'h2: duty = `PDP_DUTY_C2;
      3'h3: duty = `PDP_DUTY_C3;
      3'h4: duty = `PDP_DUTY_C4;
      3'h5: duty = `PDP_DUTY_C5;
      3'h6: duty = `PDP_DUTY_C6;
      default: duty = `PDP_DUTY_C7;
    endcase
  end

endmodule

/* File: pdp_pwm.v */
`timescale 1ns/1ps
`include "pdp_regs.vh"

module pdp_pwm #(
  parameter [`PDP_DUTY_W-1:0] STEPS = `PDP_DUTY_FULL
) (
  input wire pclk,                         // Clock
  input wire presetn,                      // Async reset, active low
  input wire enable,                       // Carrier running
  input wire [`PDP_CTRL_DIV_W-1:0] div,    // Tick divider minus one
  input wire [`PDP_DUTY_W-1:0] duty,       // Duty, hundredths of percent
  output reg pwm                           // Modulated output
);

  reg [`PDP_CTRL_DIV_W-1:0] pre;
  reg tick;
  reg [`PDP_DUTY_W-1:0] cnt;

  // One-cycle tick every div+1 clocks
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre <= {`PDP_CTRL_DIV_W{1'b0}};
      tick <= 1'b0;
    end
    else if (!enable)
    begin
      pre <= {`PDP_CTRL_DIV_W{1'b0}};
      tick <= 1'b0;
    end
    else if (pre >= div)
    begin
      pre <= {`PDP_CTRL_DIV_W{1'b0}};
      tick <= 1'b1;
    end
    else
    begin
      pre <= pre + 8'h01;
      tick <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= {`PDP_DUTY_W{1'b0}};
      pwm <= 1'b0;
    end
    else if (!enable)
    begin
      cnt <= {`PDP_DUTY_W{1'b0}};
      pwm <= 1'b0;
    end
    else
    begin
      if (tick)
      begin
        if (cnt >= STEPS - 14'h0001)
          cnt <= {`PDP_DUTY_W{1'b0}};
        else
          cnt <= cnt + 14'h0001;
      end
      // Compare against duty; 0 % stays low for the whole carrier
      pwm <= (cnt < duty);
    end
  end

endmodule

/* File: pdp_profile_regs.v */
// Operation
// [R01] Two-phase profile register at index 0x96, 32 bits, resets to zero.
// [R02] Two-phase register holds eight 3-bit step codes, step 0 at 30:28 downward.
// [R03] Codes map to 0, 50, 75, 83.75, 87.5, 93.75, 97.5, 99 percent.
// [R04] At two-phase step k the duty from two-phase field k is applied.
// [R05] Two-phase bits 6:0 are plain read/write storage, reset zero, no effect.
// [R06] Three-phase profile register at index 0x98, 32 bits, resets to zero.
// [R07] Three-phase steps 0 to 2 at 30:28, 27:25, 24:22, same code mapping.
// [R08] Three-phase steps 3 to 7 continue downward to 9:7, applied per step.
// [R09] Bit 31 of each profile is stored parity, returned as written, not checked.
`timescale 1ns/1ps
`include "pdp_regs.vh"

module pdp_profile_regs #(
  parameter [`PDP_DUTY_W-1:0] PWM_STEPS = `PDP_DUTY_FULL
) (
  input wire pclk,                         // Clock, 250 MHz
  input wire presetn,                      // Async reset, active low
  input wire psel,                         // APB select
  input wire penable,                      // APB access phase
  input wire pwrite,                       // APB write
  input wire [11:0] paddr,                 // APB byte address
  input wire [31:0] pwdata,                // APB write data
  input wire [3:0] pstrb,                  // APB byte strobes
  output reg [31:0] prdata,                // APB read data
  output reg pready,                       // APB ready
  output reg pslverr,                      // APB error, unmapped address
  input wire step_valid,                   // Modulation reached a new step
  input wire [2:0] step_idx,               // Step number within the interval
  input wire step_triple,                  // 1: three-phase step, 0: two-phase
  output reg [2:0] duty_code,              // Code in force
  output reg [`PDP_DUTY_W-1:0] duty_level, // Duty in force, hundredths of percent
  output reg duty_update,                  // Pulse: new duty in force
  output reg [31:0] two_profile,           // Two-phase profile contents
  output reg [31:0] three_profile,         // Three-phase profile contents
  output wire pwm_out                      // Carrier modulated at duty_level
);

  reg [31:0] ctrl;
  reg [2:0] cur_step;
  reg cur_triple;
  reg [15:0] step_count;
  reg [31:0] next_prdata;
  reg next_err;
  wire [2:0] sel_code;
  wire [`PDP_DUTY_W-1:0] sel_duty;
  wire setup;
  wire access;
  wire do_write;

  // Step k field sits at bits 30-3k down to 28-3k
  function [2:0] step_field;
    input [31:0] prof;
    input [2:0] k;
    reg [4:0] lsb;
    begin
      lsb = 5'd28 - {k, 1'b0} - {2'b00, k};
      step_field = prof[lsb +: `PDP_STEP_W];
    end
  endfunction

  // Word index compare; byte address is index times four
  function hit;
    input [11:0] addr;
    input [9:0] idx;
    begin
      hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  // Byte-lane merge so partial writes keep the other lanes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (strb[i])
          merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign do_write = access && pwrite && !pslverr;

  // Read data and error are prepared in the setup cycle
  always @*
  begin
    next_prdata = 32'h00000000;
    next_err = 1'b0;
    if (hit(paddr, `PDP_TWO_IDX))
      next_prdata = two_profile; // [R01] [R09]
    else if (hit(paddr, `PDP_THREE_IDX))
      next_prdata = three_profile; // [R06] [R09]
    else if (hit(paddr, `PDP_CTRL_IDX))
      next_prdata = ctrl;
    else if (hit(paddr, `PDP_STAT_IDX))
    begin
      next_prdata[`PDP_STAT_STEP_LSB +: 3] = cur_step;
      next_prdata[`PDP_STAT_MODE_BIT] = cur_triple;
      next_prdata[`PDP_STAT_CODE_LSB +: 3] = duty_code;
      next_prdata[`PDP_STAT_PWM_BIT] = pwm_out;
      next_prdata[`PDP_STAT_CNT_LSB +: 16] = step_count;
    end
    else
      next_err = 1'b1;
  end

  // Zero-wait slave: ready in the first access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (setup)
    begin
      pready <= 1'b1;
      pslverr <= next_err;
      prdata <= pwrite ? 32'h00000000 : next_prdata;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // Whole-word storage, parity and reserved bits included
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      two_profile <= `PDP_TWO_RESET; // [R01] [R05]
      three_profile <= `PDP_THREE_RESET; // [R06]
      ctrl <= `PDP_CTRL_RESET;
    end
    else if (do_write)
    begin
      if (hit(paddr, `PDP_TWO_IDX))
        two_profile <= merge(two_profile, pwdata, pstrb); // [R02] [R05] [R09]
      if (hit(paddr, `PDP_THREE_IDX))
        three_profile <= merge(three_profile, pwdata, pstrb); // [R07] [R08] [R09]
      if (hit(paddr, `PDP_CTRL_IDX))
        ctrl <= merge(ctrl, pwdata, pstrb);
    end
  end

  // Code picked from the profile matching the interval kind
  assign sel_code = step_triple ? step_field(three_profile, step_idx) // [R07] [R08]
                                : step_field(two_profile, step_idx); // [R02] [R04]

  pdp_duty_lut u_lut (
    .code(sel_code),
    .duty(sel_duty)
  );

  // Duty latched at the step so a mid-step profile write waits for the next step
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      duty_code <= 3'h0;
      duty_level <= `PDP_DUTY_C0;
      duty_update <= 1'b0;
      cur_step <= 3'h0;
      cur_triple <= 1'b0;
      step_count <= 16'h0000;
    end
    else if (step_valid)
    begin
      duty_code <= sel_code; // [R04] [R08]
      duty_level <= sel_duty; // [R03]
      duty_update <= 1'b1;
      cur_step <= step_idx;
      cur_triple <= step_triple;
      step_count <= step_count + 16'h0001;
    end
    else
      duty_update <= 1'b0;
  end

  pdp_pwm #(
    .STEPS(PWM_STEPS)
  ) u_pwm (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ctrl[`PDP_CTRL_EN_BIT]),
    .div(ctrl[`PDP_CTRL_DIV_LSB +: `PDP_CTRL_DIV_W]),
    .duty(duty_level),
    .pwm(pwm_out)
  );

endmodule

/* File: pdp_profile_regs_checker.sv */
`timescale 1ns/1ps
module pdp_profile_regs_checker (
  input logic pclk, // Clock
  input logic presetn, // Reset, low
  input logic psel, // Select
  input logic penable, // Access
  input logic pwrite, // Write
  input logic [11:0] paddr, // Address
  input logic [31:0] pwdata, // Write data
  input logic [3:0] pstrb, // Strobes
  input logic pready, // Ready
  input logic pslverr, // Error
  input logic step_valid, // Step pulse
  input logic [2:0] step_idx, // Step k
  input logic step_triple, // Kind
  input logic [2:0] duty_code, // Code
  input logic [13:0] duty_level, // Duty
  input logic duty_update, // New duty
  input logic [31:0] two_profile, // Two-phase
  input logic [31:0] three_profile, // Three-phase
  input logic pwm_out // Carrier
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr;
    psel && penable && pready && pwrite && pstrb == 4'hf;
  endsequence
  a_ready_once: assert property (s_setup |=> pready ##1 !pready)
    else $error("ready timing");
  a_err_unmapped: assert property (s_setup and !(paddr inside {12'h258, 12'h260, 12'h270,
    12'h274}) |=> pslverr) else $error("no error on unmapped");
  a_write_two: assert property (s_wr ##0 paddr == 12'h258 |=> two_profile == $past(pwdata))
    else $error("two-phase write lost");
  a_reset_zero: assert property ($rose(presetn) |-> two_profile == 32'h0 &&
    three_profile == 32'h0) else $error("profiles not zero");
  a_code_two: assert property (step_valid && !step_triple |=> duty_update &&
    duty_code == $past(two_profile[30 - 3 * step_idx -: 3])) else $error("two-phase code");
  a_code_three: assert property (step_valid && step_triple |=> duty_update &&
    duty_code == $past(three_profile[30 - 3 * step_idx -: 3])) else $error("three code");
  a_duty_map: assert property (duty_update && duty_code == 3'h3 |-> duty_level == 14'h20b7)
    else $error("duty map");
  a_hold_code: assert property (!step_valid |=> $stable(duty_code) && !duty_update)
    else $error("duty moved");
  a_pwm_zero: assert property (duty_level == 14'h0000 |=> !pwm_out)
    else $error("carrier high at zero duty");
endmodule
bind pdp_profile_regs pdp_profile_regs_checker pdp_profile_regs_checker_i (.*);

/* File: test_pdp_profile_regs.sv */
`timescale 1ns/1ps
module test_pdp_profile_regs;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 4'hf;
  logic step_valid = 0;
  logic step_triple = 0;
  logic [2:0] step_idx = 0;
  logic [31:0] prdata, two_profile, three_profile, rd, v2, v3;
  logic [31:0] seed = 32'h4d;
  logic pready, pslverr, err, duty_update, pwm_out;
  logic [2:0] duty_code;
  logic [13:0] duty_level;
  logic [13:0] dtab [8] = '{14'h0, 14'h1388, 14'h1d4c, 14'h20b7, 14'h222e, 14'h249f,
    14'h2616, 14'h26ac};
  int error_cnt = 0;
  int compares = 0;
  always #2 pclk = ~pclk;
  pdp_profile_regs #(.PWM_STEPS(14'h14)) pdp_profile_regs_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_valid(step_valid), .step_idx(step_idx), .step_triple(step_triple),
    .duty_code(duty_code), .duty_level(duty_level), .duty_update(duty_update),
    .two_profile(two_profile), .three_profile(three_profile), .pwm_out(pwm_out));
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [2:0] fld(input logic [31:0] p, input logic [2:0] k);
    return p[30 - 3 * k -: 3];
  endfunction
  task end_of_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask
  // Step result lands one edge after the pulse, so look just past it
  task step(input logic t, input logic [2:0] k, input logic [31:0] p);
    @(posedge pclk);
    step_valid <= 1;
    step_triple <= t;
    step_idx <= k;
    @(posedge pclk);
    step_valid <= 0;
    #1;
    chk("duty_code", fld(p, k), duty_code);
    chk("duty_level", dtab[fld(p, k)], duty_level);
    chk("duty_update", 1, duty_update);
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h258, 0);
    chk("two_reset", 0, rd);
    apb(0, 12'h260, 0);
    chk("three_reset", 0, rd);
    apb(1, 12'h25c, seed);
    chk("unmapped_err", 1, err);
    $display("reset and map test done");
    for (int i = 0; i < 6; i++)
    begin
      v2 = seed;
      seed = lfsr(seed);
      v3 = seed;
      seed = lfsr(seed);
      // First pass puts code k in two-phase field k and code 7-k in three-phase field k
      if (i == 0)
        for (int k = 0; k < 8; k++)
        begin
          v2[30 - 3 * k -: 3] = k[2:0];
          v3[30 - 3 * k -: 3] = 3'h7 - k[2:0];
        end
      apb(1, 12'h258, v2);
      apb(1, 12'h260, v3);
      apb(0, 12'h258, 0);
      chk("two_read", v2, rd);
      chk("two_port", v2, two_profile);
      apb(0, 12'h260, 0);
      chk("three_read", v3, rd);
      chk("three_port", v3, three_profile);
      for (int k = 0; k < 8; k++)
      begin
        step(0, k[2:0], v2);
        step(1, k[2:0], v3);
      end
      $display("profile pass %0d done", i);
    end
    // Carrier enabled with divider 0; one strobed lane sets step 0 to code 7
    apb(1, 12'h270, 32'h00000001);
    apb(0, 12'h270, 32'h00000000);
    chk("ctrl_read", 32'h00000001, rd);
    pstrb <= 4'h8;
    apb(1, 12'h258, 32'h70000000);
    pstrb <= 4'hf;
    v2 = {8'h70, v2[23:0]};
    step(0, 3'h0, v2);
    chk("two_lane", v2, two_profile);
    @(posedge pclk);
    #1;
    chk("pwm_on", 1, pwm_out);
    apb(1, 12'h258, 32'h00000000);
    step(0, 3'h0, 32'h00000000);
    @(posedge pclk);
    #1;
    chk("pwm_off", 0, pwm_out);
    // 96 loop steps plus the two above
    apb(0, 12'h274, 32'h00000000);
    chk("status", 32'h00620000, rd);
    $display("carrier and status test done");
    end_of_test();
  end
endmodule
